// File: rtl/oag_top.sv
// Operand address generator: registers a request, forms the address,
// drives the internal bus and holds the first port's pin direction SFR.
// Assumes the core supplies register-bank pairs and a stable request.
//
// Operation
// RL1 - Direct mode passes the 16-bit immediate unchanged as the address.
// RL2 - Short direct mode reaches only the 256-byte window FE20H to FF1FH via an 8-bit field.
// RL3 - Short direct bit 8 is 0 for fields 20H to FFH and 1 for fields 00H to 1FH.
// RL4 - In that window FE20H-FEFFH selects RAM and FF00H-FF1FH selects SFRs.
// RL5 - The word form of short direct accepts only even addresses.
// RL6 - SFR mode selects FF00H-FFCFH or FFE0H-FFFFH, 240 bytes in all.
// RL7 - SFR word accesses are allowed only at even addresses.
// RL8 - Register indirect uses DE or HL of the selected bank over all memory.
// RL9 - Based mode adds a zero-extended 8-bit offset to HL, dropping carry.
// RL10 - Based indexed mode adds zero-extended B or C to HL, dropping carry.
// RL11 - Opcode 10101011 loads A from HL plus B.
// RL12 - Stack accesses go through the stack pointer for push, pop, call, return, interrupt.
// RL13 - Stack accesses reach only internal high-speed RAM.
// RL14 - The port 0 pin direction register answers at SFR address FF20H.
// RL15 - Short direct address is seven ones, derived bit 8, then the field.
// RL16 - SFR address is FFH above the 8-bit field.
`timescale 1ns/1ps
`default_nettype none
`include "oag_cfg.svh"

module oag_top
#(
  parameter int PDIR_W = 8   // Width of port 0 pin direction register
)
(
  input  wire logic               core_clk_in,      // Core clock
  input  wire logic               sys_rst_in,       // Sync reset, high
  input  wire logic               clk_en_in,        // Freezes state when low
  input  wire logic               req_in,           // Operand request pulse
  input  wire oag_pkg::oag_mode_t mode_in,          // Addressing mode
  input  wire logic               opc_valid_in,     // Opcode byte valid
  input  wire logic [7:0]         opcode_in,        // Opcode byte
  input  wire logic               word_in,          // 16-bit operand
  input  wire logic               write_in,         // Write access
  input  wire logic [7:0]         imm8_in,          // 8-bit field/offset
  input  wire logic [15:0]        full_address_immediate_in, // 16-bit immediate
  input  wire logic               bank_select_low_in,  // Bank select bit 0
  input  wire logic               bank_select_high_in, // Bank select bit 1
  input  wire logic [63:0]        bank_hl_in,       // HL of banks 0..3
  input  wire logic [63:0]        bank_de_in,       // DE of banks 0..3
  input  wire logic [63:0]        bank_bc_in,       // BC of banks 0..3
  input  wire logic [15:0]        sp_in,            // Stack pointer
  input  wire logic [7:0]         wdata_in,         // Write data
  output logic                    bus_valid_out,    // Address valid
  output logic [15:0]             bus_addr_out,     // Operand address
  output oag_pkg::oag_tgt_t       bus_tgt_out,      // Target area
  output logic                    bus_write_out,    // Write strobe
  output logic                    bus_word_out,     // Word access
  output logic                    fault_out,        // Illegal address
  output logic                    load_a_out,       // Load-A decode seen
  output logic [7:0]              sfr_rdata_out,    // Local SFR read data
  output logic                    sfr_hit_out,      // Local SFR hit
  output logic [PDIR_W-1:0]       port0_pin_direction_out // Pin directions
);

  // ------------------------------------------------------------
  // Bank selection
  // ------------------------------------------------------------
  logic [1:0]  bank_w;
  logic [15:0] hl_w;
  logic [15:0] de_w;
  logic [15:0] bc_w;

  assign bank_w = {bank_select_high_in, bank_select_low_in};

  always_comb
  begin
    hl_w = bank_hl_in[16*bank_w +: 16]; // RL8
    de_w = bank_de_in[16*bank_w +: 16]; // RL8
    bc_w = bank_bc_in[16*bank_w +: 16];
  end

  // ------------------------------------------------------------
  // Request register
  // ------------------------------------------------------------
  oag_pkg::oag_mode_t mode_q, mode_d;
  logic        valid_q, valid_d;
  logic        word_q, word_d;
  logic        write_q, write_d;
  logic        lda_q, lda_d;
  logic [7:0]  imm8_q, imm8_d;
  logic [15:0] imm16_q, imm16_d;
  logic [15:0] hl_q, hl_d;
  logic [15:0] de_q, de_d;
  logic [15:0] bc_q, bc_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        is_lda_w;

  // Single opcode byte implies based indexed with B, byte read into A
  assign is_lda_w = opc_valid_in && (opcode_in == `OAG_OPC_LD_A_HLB); // RL11

  always_comb
  begin
    valid_d = 1'b0;
    mode_d  = mode_q;
    word_d  = word_q;
    write_d = write_q;
    lda_d   = 1'b0;
    imm8_d  = imm8_q;
    imm16_d = imm16_q;
    hl_d    = hl_q;
    de_d    = de_q;
    bc_d    = bc_q;
    sp_d    = sp_q;
    wdata_d = wdata_q;
    if (req_in || is_lda_w)
    begin
      valid_d = 1'b1;
      mode_d  = is_lda_w ? oag_pkg::OAG_MODE_IDX_B : mode_in; // RL11
      word_d  = is_lda_w ? 1'b0 : word_in;
      write_d = is_lda_w ? 1'b0 : write_in;
      lda_d   = is_lda_w;
      imm8_d  = imm8_in;
      imm16_d = full_address_immediate_in;
      hl_d    = hl_w;
      de_d    = de_w;
      bc_d    = bc_w;
      sp_d    = sp_in; // RL12
      wdata_d = wdata_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      valid_q <= 1'b0;
      mode_q  <= oag_pkg::OAG_MODE_DIRECT;
      word_q  <= 1'b0;
      write_q <= 1'b0;
      lda_q   <= 1'b0;
      imm8_q  <= 8'h00;
      imm16_q <= 16'h0000;
      hl_q    <= 16'h0000;
      de_q    <= 16'h0000;
      bc_q    <= 16'h0000;
      sp_q    <= 16'h0000;
      wdata_q <= 8'h00;
    end
    else if (clk_en_in)
    begin
      valid_q <= valid_d;
      mode_q  <= mode_d;
      word_q  <= word_d;
      write_q <= write_d;
      lda_q   <= lda_d;
      imm8_q  <= imm8_d;
      imm16_q <= imm16_d;
      hl_q    <= hl_d;
      de_q    <= de_d;
      bc_q    <= bc_d;
      sp_q    <= sp_d;
      wdata_q <= wdata_d;
    end
  end

  // ------------------------------------------------------------
  // Address calculation
  // ------------------------------------------------------------
  oag_calc_if cif ();

  assign cif.mode  = mode_q;
  assign cif.imm8  = imm8_q;
  assign cif.imm16 = imm16_q;
  assign cif.hl    = hl_q;
  assign cif.de    = de_q;
  assign cif.reg_b = bc_q[15:8];
  assign cif.reg_c = bc_q[7:0];
  assign cif.sp    = sp_q;
  assign cif.word  = word_q;

  oag_calc u_calc
  (
    .c (cif.calc)
  );

  // ------------------------------------------------------------
  // Bus output register
  // ------------------------------------------------------------
  logic              ovalid_q, ovalid_d;
  logic [15:0]       oaddr_q, oaddr_d;
  oag_pkg::oag_tgt_t otgt_q, otgt_d;
  logic              owrite_q, owrite_d;
  logic              oword_q, oword_d;
  logic              ofault_q, ofault_d;
  logic              olda_q, olda_d;

  always_comb
  begin
    ovalid_d = valid_q && !cif.fault; // RL2
    oaddr_d  = oaddr_q;
    otgt_d   = otgt_q;
    owrite_d = 1'b0;
    oword_d  = oword_q;
    ofault_d = valid_q && cif.fault; // RL5
    olda_d   = valid_q && lda_q; // RL11
    if (valid_q)
    begin
      oaddr_d  = cif.addr;
      otgt_d   = cif.tgt; // RL4
      owrite_d = write_q && !cif.fault;
      oword_d  = word_q;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      ovalid_q <= 1'b0;
      oaddr_q  <= 16'h0000;
      otgt_q   <= oag_pkg::OAG_TGT_NONE;
      owrite_q <= 1'b0;
      oword_q  <= 1'b0;
      ofault_q <= 1'b0;
      olda_q   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ovalid_q <= ovalid_d;
      oaddr_q  <= oaddr_d;
      otgt_q   <= otgt_d;
      owrite_q <= owrite_d;
      oword_q  <= oword_d;
      ofault_q <= ofault_d;
      olda_q   <= olda_d;
    end
  end

  // ------------------------------------------------------------
  // Port 0 pin direction register
  // ------------------------------------------------------------
  logic [PDIR_W-1:0] pdir_q, pdir_d;
  logic              pdir_hit_w;

  // Byte and word accesses both hit; a word at FF20H would also touch FF21H elsewhere
  assign pdir_hit_w = valid_q && !cif.fault && (cif.addr == `OAG_PDIR0_ADDR); // RL14

  always_comb
  begin
    pdir_d = pdir_q;
    if (pdir_hit_w && write_q)
      pdir_d = wdata_q[PDIR_W-1:0]; // RL14
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      pdir_q <= PDIR_W'(`OAG_PDIR0_RESET);
    else if (clk_en_in)
      pdir_q <= pdir_d;
  end

  // ------------------------------------------------------------
  // Local SFR read return
  // ------------------------------------------------------------
  // Unmatched reads return zero so several returns can be ORed
  logic        shit_q, shit_d;
  logic [7:0]  srd_q, srd_d;

  always_comb
  begin
    shit_d = pdir_hit_w && !write_q;
    srd_d  = shit_d ? 8'(pdir_q) : 8'h00;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      shit_q <= 1'b0;
      srd_q  <= 8'h00;
    end
    else if (clk_en_in)
    begin
      shit_q <= shit_d;
      srd_q  <= srd_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output comes straight from a flop, no glitches on the bus
  assign bus_valid_out           = ovalid_q;
  assign bus_addr_out            = oaddr_q;
  assign bus_tgt_out             = otgt_q;
  assign bus_write_out           = owrite_q;
  assign bus_word_out            = oword_q;
  assign fault_out               = ofault_q;
  assign load_a_out              = olda_q;
  assign sfr_rdata_out           = srd_q;
  assign sfr_hit_out             = shit_q;
  assign port0_pin_direction_out = pdir_q;

endmodule

`default_nettype wire

// File: rtl/oag_cfg.svh
// Address constants for the operand address generator.
// Assumes inclusion by the design files only.
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH

`define OAG_SADDR_BASE_HI   7'h7F
`define OAG_SADDR_WRAP_LIM  8'h20
`define OAG_SADDR_LO        16'hFE20
`define OAG_SADDR_HI        16'hFF1F
`define OAG_RAM_LAST        16'hFEFF
`define OAG_SFR_BASE        16'hFF00
`define OAG_SFR_HI_BYTE     8'hFF
`define OAG_SFR_GAP_LO      8'hD0
`define OAG_SFR_GAP_HI      8'hDF
`define OAG_PDIR0_ADDR      16'hFF20
`define OAG_PDIR0_RESET     8'hFF
`define OAG_OPC_LD_A_HLB    8'hAB
`define OAG_HSRAM_LO        16'hFB00
`define OAG_HSRAM_HI        16'hFEFF

`endif

// File: rtl/oag_pkg.sv
// Types shared by the operand address generator files.
// Assumes the constants header is available on the include path.
package oag_pkg;

  typedef enum logic [3:0]
  {
    OAG_MODE_DIRECT,
    OAG_MODE_SHORT,
    OAG_MODE_SFR,
    OAG_MODE_IND_DE,
    OAG_MODE_IND_HL,
    OAG_MODE_BASED,
    OAG_MODE_IDX_B,
    OAG_MODE_IDX_C,
    OAG_MODE_STACK
  } oag_mode_t;

  typedef enum logic [1:0]
  {
    OAG_TGT_RAM,
    OAG_TGT_SFR,
    OAG_TGT_MEM,
    OAG_TGT_NONE
  } oag_tgt_t;

endpackage

// File: rtl/oag_calc_if.sv
// Carrier between the request stage and the address calculator.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface oag_calc_if;
  oag_pkg::oag_mode_t mode;
  logic [7:0]         imm8;
  logic [15:0]        imm16;
  logic [15:0]        hl;
  logic [15:0]        de;
  logic [7:0]         reg_b;
  logic [7:0]         reg_c;
  logic [15:0]        sp;
  logic               word;
  logic [15:0]        addr;
  oag_pkg::oag_tgt_t  tgt;
  logic               fault;

  modport req  (output mode, imm8, imm16, hl, de, reg_b, reg_c, sp, word,
                input addr, tgt, fault);
  modport calc (input mode, imm8, imm16, hl, de, reg_b, reg_c, sp, word,
                output addr, tgt, fault);
endinterface

`default_nettype wire

// File: rtl/oag_calc.sv
// Combinational effective-address calculator for all operand modes.
// Assumes inputs are stable registered values from the top module.
`timescale 1ns/1ps
`default_nettype none
`include "oag_cfg.svh"

module oag_calc
(
  oag_calc_if.calc c   // Request and result
);

  logic [15:0] addr_w;
  logic        bit8_w;

  always_comb
  begin
    bit8_w = (c.imm8 < `OAG_SADDR_WRAP_LIM); // RL3
    addr_w = c.imm16;
    case (c.mode)
      oag_pkg::OAG_MODE_DIRECT: addr_w = c.imm16; // RL1
      oag_pkg::OAG_MODE_SHORT:  addr_w = {`OAG_SADDR_BASE_HI, bit8_w, c.imm8}; // RL15
      oag_pkg::OAG_MODE_SFR:    addr_w = {`OAG_SFR_HI_BYTE, c.imm8}; // RL16
      oag_pkg::OAG_MODE_IND_DE: addr_w = c.de; // RL8
      oag_pkg::OAG_MODE_IND_HL: addr_w = c.hl; // RL8
      oag_pkg::OAG_MODE_BASED:  addr_w = c.hl + {8'h00, c.imm8}; // RL9
      oag_pkg::OAG_MODE_IDX_B:  addr_w = c.hl + {8'h00, c.reg_b}; // RL10
      oag_pkg::OAG_MODE_IDX_C:  addr_w = c.hl + {8'h00, c.reg_c}; // RL10
      oag_pkg::OAG_MODE_STACK:  addr_w = c.sp; // RL12
      default:                  addr_w = c.imm16;
    endcase
  end

  always_comb
  begin
    c.addr  = addr_w;
    c.fault = 1'b0;
    c.tgt   = oag_pkg::OAG_TGT_MEM;
    case (c.mode)
      oag_pkg::OAG_MODE_SHORT:
      begin
        // Window stays FE20..FF1F by construction of bit 8
        if (addr_w <= `OAG_RAM_LAST) c.tgt = oag_pkg::OAG_TGT_RAM; // RL4
        else c.tgt = oag_pkg::OAG_TGT_SFR; // RL4
        if (c.word && addr_w[0]) c.fault = 1'b1; // RL5
      end
      oag_pkg::OAG_MODE_SFR:
      begin
        c.tgt = oag_pkg::OAG_TGT_SFR;
        if (c.imm8 >= `OAG_SFR_GAP_LO && c.imm8 <= `OAG_SFR_GAP_HI)
          c.fault = 1'b1; // RL6
        if (c.word && addr_w[0]) c.fault = 1'b1; // RL7
      end
      oag_pkg::OAG_MODE_STACK:
      begin
        c.tgt = oag_pkg::OAG_TGT_RAM;
        if (addr_w < `OAG_HSRAM_LO || addr_w > `OAG_HSRAM_HI)
          c.fault = 1'b1; // RL13
      end
      default: c.tgt = oag_pkg::OAG_TGT_MEM;
    endcase
    if (c.fault) c.tgt = oag_pkg::OAG_TGT_NONE;
  end

endmodule

`default_nettype wire

// File: verification/oag_top_assertions.sv
// Port checker for the operand address generator.
// Assumes one clock domain; bound onto every oag_top.
`timescale 1ns/1ps
`default_nettype none

module oag_top_assertions
(
  input wire logic               core_clk_in,         // Clock
  input wire logic               sys_rst_in,          // Reset
  input wire logic               clk_en_in,           // Enable
  input wire logic               req_in,              // Request
  input wire oag_pkg::oag_mode_t mode_in,             // Mode
  input wire logic               opc_valid_in,        // Opcode valid
  input wire logic [7:0]         opcode_in,           // Opcode
  input wire logic               word_in,             // Word
  input wire logic               write_in,            // Write
  input wire logic [7:0]         imm8_in,             // Field
  input wire logic [15:0]        full_address_immediate_in, // Immediate
  input wire logic               bank_select_low_in,  // Bank bit 0
  input wire logic               bank_select_high_in, // Bank bit 1
  input wire logic [63:0]        bank_hl_in,          // HL pairs
  input wire logic [63:0]        bank_bc_in,          // BC pairs
  input wire logic [15:0]        sp_in,               // Stack pointer
  input wire logic [7:0]         wdata_in,            // Write data
  input wire logic               bus_valid_out,       // Valid
  input wire logic [15:0]        bus_addr_out,        // Address
  input wire oag_pkg::oag_tgt_t  bus_tgt_out,         // Target
  input wire logic               fault_out,           // Fault
  input wire logic               load_a_out,          // Load A
  input wire logic [7:0]         port0_pin_direction_out // Pins
);
  wire logic [1:0]  bk   = {bank_select_high_in, bank_select_low_in};
  wire logic [15:0] hl   = bank_hl_in[bk*16 +: 16];
  wire logic [15:0] hl_b = hl + {8'h00, bank_bc_in[bk*16+8 +: 8]};
  wire logic [15:0] hl_k = hl + {8'h00, imm8_in};

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Request taken, then one more enabled edge before the answer
  sequence s_take(logic [3:0] m, logic w);
    clk_en_in && req_in && !opc_valid_in && mode_in == m && word_in == w ##1 clk_en_in;
  endsequence

  direct_addr_a: assert property (
    s_take(oag_pkg::OAG_MODE_DIRECT, 1'b0) |=> bus_valid_out &&
    bus_addr_out == $past(full_address_immediate_in, 2)) else $error("direct address wrong");
  short_addr_a: assert property (
    s_take(oag_pkg::OAG_MODE_SHORT, 1'b0) |=> bus_valid_out &&
    bus_addr_out == {7'h7F, $past(imm8_in, 2) < 8'h20, $past(imm8_in, 2)})
    else $error("short address wrong");
  short_tgt_a: assert property (
    s_take(oag_pkg::OAG_MODE_SHORT, 1'b0) |=> bus_tgt_out == ($past(imm8_in, 2) < 8'h20 ?
    oag_pkg::OAG_TGT_SFR : oag_pkg::OAG_TGT_RAM)) else $error("short target wrong");
  odd_word_a: assert property (
    clk_en_in && req_in && !opc_valid_in && word_in && imm8_in[0] &&
    mode_in inside {oag_pkg::OAG_MODE_SHORT, oag_pkg::OAG_MODE_SFR} ##1 clk_en_in
    |=> fault_out && !bus_valid_out) else $error("odd word not refused");
  sfr_addr_a: assert property (
    s_take(oag_pkg::OAG_MODE_SFR, 1'b0) |=> fault_out == ($past(imm8_in, 2) inside
    {[8'hD0:8'hDF]}) && (fault_out || bus_addr_out == {8'hFF, $past(imm8_in, 2)}))
    else $error("sfr address wrong");
  ind_addr_a: assert property (
    s_take(oag_pkg::OAG_MODE_IND_HL, 1'b0) |=> bus_addr_out == $past(hl, 2))
    else $error("indirect address wrong");
  based_add_a: assert property (
    s_take(oag_pkg::OAG_MODE_BASED, 1'b0) |=> bus_addr_out == $past(hl_k, 2))
    else $error("based address wrong");
  load_a_a: assert property (
    clk_en_in && opc_valid_in && opcode_in == 8'hAB ##1 clk_en_in |=> load_a_out &&
    bus_addr_out == $past(hl_b, 2)) else $error("load A address wrong");
  stack_area_a: assert property (
    s_take(oag_pkg::OAG_MODE_STACK, 1'b0) |=> fault_out == !($past(sp_in, 2) inside
    {[16'hFB00:16'hFEFF]}) && (fault_out || bus_addr_out == $past(sp_in, 2)))
    else $error("stack access wrong");
  pin_dir_a: assert property (
    s_take(oag_pkg::OAG_MODE_SFR, 1'b0) and write_in && imm8_in == 8'h20 ##1 1'b1
    |=> port0_pin_direction_out == $past(wdata_in, 2)) else $error("pin direction wrong");
endmodule

bind oag_top oag_top_assertions oag_top_assertions_i (.*);

`default_nettype wire

// File: verification/oag_bus_model.sv
// Stand-in for the internal memory and SFR bus.
// Assumes one valid pulse per accepted access.
`timescale 1ns/1ps
`default_nettype none

module oag_bus_model
(
  input  wire logic clk_in,   // Core clock
  input  wire logic rst_in,   // Sync reset
  input  wire logic valid_in, // Access strobe
  output var  int   hits_out  // Accesses seen
);
  // Counting strobes catches stretched or doubled pulses
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      hits_out <= 0;
    else if (valid_in)
      hits_out <= hits_out + 1;
  end
endmodule

`default_nettype wire

// File: verification/tb_oag_top.sv
// Self-checking bench for the operand address generator.
// Assumes the checker binds itself onto oag_top.
`timescale 1ns/1ps
`default_nettype none

module tb_oag_top;
  typedef struct packed
  {
    logic [3:0]  m;
    logic [7:0]  i8;
    logic [15:0] i16;
    logic        w;
    logic [15:0] ea;
    logic        f;
  } oag_row_t;

  logic               core_clk_in, sys_rst_in, clk_en_in, req_in, opc_valid_in, word_in;
  logic               write_in, bank_select_low_in, bank_select_high_in, bus_valid_out;
  logic               bus_write_out, bus_word_out, fault_out, load_a_out, sfr_hit_out;
  oag_pkg::oag_mode_t mode_in;
  oag_pkg::oag_tgt_t  bus_tgt_out;
  logic [7:0]         opcode_in, imm8_in, wdata_in, sfr_rdata_out, port0_pin_direction_out;
  logic [15:0]        full_address_immediate_in, sp_in, bus_addr_out;
  logic [63:0]        bank_hl_in, bank_de_in, bank_bc_in;
  int                 error_cnt, samples_checked, hits, nv;
  oag_row_t           rows [0:15];

  oag_top oag_top_i (.*);
  oag_bus_model oag_bus_model_i (.clk_in(core_clk_in), .rst_in(sys_rst_in),
                                 .valid_in(bus_valid_out), .hits_out(hits));

  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Answer stands one cycle, one edge after the taking edge
  task automatic access(input logic [3:0] m, input logic [7:0] i8, input logic [15:0] i16,
                        input logic w, input logic wr, input logic opc);
    @(posedge core_clk_in);
    req_in <= 1'b1;
    mode_in <= oag_pkg::oag_mode_t'(m);
    imm8_in <= i8;
    full_address_immediate_in <= i16;
    sp_in <= i16;
    wdata_in <= i16[7:0];
    word_in <= w;
    write_in <= wr;
    opc_valid_in <= opc;
    @(posedge core_clk_in);
    req_in <= 1'b0;
    write_in <= 1'b0;
    opc_valid_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  initial
  begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    {sys_rst_in, clk_en_in, bank_select_high_in} = 3'b111;
    {req_in, opc_valid_in, word_in, write_in, bank_select_low_in} = 5'b00000;
    mode_in = oag_pkg::OAG_MODE_DIRECT;
    {opcode_in, imm8_in, wdata_in} = {8'hAB, 16'h0000};
    {full_address_immediate_in, sp_in} = 32'h0000_0000;
    bank_hl_in = 64'h4444_FFF0_2222_1111;
    bank_de_in = 64'h8888_1234_6666_5555;
    bank_bc_in = 64'hAAAA_2030_CCCC_DDDD;
    rows[0] = '{oag_pkg::OAG_MODE_DIRECT, 8'h00, 16'hFE00, 1'b0, 16'hFE00, 1'b0};
    rows[1] = '{oag_pkg::OAG_MODE_SHORT, 8'h30, 16'h0000, 1'b0, 16'hFE30, 1'b0};
    rows[2] = '{oag_pkg::OAG_MODE_SHORT, 8'h1F, 16'h0000, 1'b0, 16'hFF1F, 1'b0};
    rows[3] = '{oag_pkg::OAG_MODE_SHORT, 8'h20, 16'h0000, 1'b0, 16'hFE20, 1'b0};
    rows[4] = '{oag_pkg::OAG_MODE_SHORT, 8'h31, 16'h0000, 1'b1, 16'h0000, 1'b1};
    rows[5] = '{oag_pkg::OAG_MODE_SFR, 8'hCF, 16'h0000, 1'b0, 16'hFFCF, 1'b0};
    rows[6] = '{oag_pkg::OAG_MODE_SFR, 8'hD5, 16'h0000, 1'b0, 16'h0000, 1'b1};
    rows[7] = '{oag_pkg::OAG_MODE_SFR, 8'hE0, 16'h0000, 1'b0, 16'hFFE0, 1'b0};
    rows[8] = '{oag_pkg::OAG_MODE_SFR, 8'h21, 16'h0000, 1'b1, 16'h0000, 1'b1};
    rows[9] = '{oag_pkg::OAG_MODE_IND_DE, 8'h00, 16'h0000, 1'b0, 16'h1234, 1'b0};
    rows[10] = '{oag_pkg::OAG_MODE_IND_HL, 8'h00, 16'h0000, 1'b0, 16'hFFF0, 1'b0};
    rows[11] = '{oag_pkg::OAG_MODE_BASED, 8'hF0, 16'h0000, 1'b0, 16'h00E0, 1'b0};
    rows[12] = '{oag_pkg::OAG_MODE_IDX_B, 8'h00, 16'h0000, 1'b0, 16'h0010, 1'b0};
    rows[13] = '{oag_pkg::OAG_MODE_IDX_C, 8'h00, 16'h0000, 1'b0, 16'h0020, 1'b0};
    rows[14] = '{oag_pkg::OAG_MODE_STACK, 8'h00, 16'hFB00, 1'b0, 16'hFB00, 1'b0};
    rows[15] = '{oag_pkg::OAG_MODE_STACK, 8'h00, 16'hFA00, 1'b0, 16'h0000, 1'b1};
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    chk(port0_pin_direction_out, 16'h00FF);
    chk(bus_tgt_out, 16'h0003);
    $display("test reset done");
    foreach (rows[k])
    begin
      access(rows[k].m, rows[k].i8, rows[k].i16, rows[k].w, 1'b0, 1'b0);
      nv += !rows[k].f;
      chk(fault_out, rows[k].f);
      chk(bus_valid_out, !rows[k].f);
      chk(bus_word_out, rows[k].w);
      if (!rows[k].f)
        chk(bus_addr_out, rows[k].ea);
      else
        chk(bus_tgt_out, 16'h0003);
    end
    $display("test table done");
    access(oag_pkg::OAG_MODE_SFR, 8'h20, 16'h0005, 1'b0, 1'b1, 1'b0);
    chk(port0_pin_direction_out, 16'h0005);
    chk(bus_write_out, 16'h0001);
    access(oag_pkg::OAG_MODE_SFR, 8'h20, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk(sfr_hit_out, 16'h0001);
    chk(sfr_rdata_out, 16'h0005);
    $display("test pin direction done");
    access(oag_pkg::OAG_MODE_DIRECT, 8'h00, 16'h1000, 1'b0, 1'b0, 1'b1);
    chk(load_a_out, 16'h0001);
    chk(bus_addr_out, 16'h0010);
    @(posedge core_clk_in);
    #1;
    chk(hits[15:0], nv[15:0] + 16'h0003);
    $display("test load A done");
    @(posedge core_clk_in);
    req_in <= 1'b1;
    mode_in <= oag_pkg::OAG_MODE_DIRECT;
    full_address_immediate_in <= 16'h5A5A;
    @(posedge core_clk_in);
    req_in <= 1'b0;
    clk_en_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    #1;
    chk(bus_valid_out, 16'h0000);
    @(posedge core_clk_in);
    #1;
    chk(bus_valid_out, 16'h0001);
    chk(bus_addr_out, 16'h5A5A);
    $display("test clock enable done");
    access(oag_pkg::OAG_MODE_SFR, 8'h20, 16'h0033, 1'b0, 1'b1, 1'b0);
    chk(port0_pin_direction_out, 16'h0033);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    bank_select_high_in <= 1'b0;
    bank_select_low_in <= 1'b1;
    #1;
    chk(port0_pin_direction_out, 16'h00FF);
    chk(bus_valid_out, 16'h0000);
    access(oag_pkg::OAG_MODE_IND_DE, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk(bus_addr_out, 16'h6666);
    access(oag_pkg::OAG_MODE_SFR, 8'hD5, 16'h0077, 1'b0, 1'b1, 1'b0);
    chk(bus_write_out, 16'h0000);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
